// *** hw/post_supervisor.sv ***
// power-on self-test supervisor with error hold, recovery and help screens
`timescale 1ns/1ps
module post_supervisor #(
	parameter int MAIN_W = 20,
	parameter int TOTAL_W = 27
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	output logic [5:0] test_start,
	input wire logic test_done,
	input wire logic test_pass,
	input wire logic up_input_n,
	input wire logic down_input_n,
	input wire logic reset_key,
	input wire logic help_key,
	input wire logic down_key,
	input wire logic cmd_valid,
	output logic reply_valid,
	output logic [7:0] reply_char0,
	output logic [7:0] reply_char1,
	output logic [1:0] nv_action,
	output logic running,
	output logic error_shown,
	output logic [2:0] error_digit,
	output logic relay_out,
	output logic xstr1_out,
	output logic xstr2_out,
	input wire logic relay_req,
	input wire logic xstr1_req,
	input wire logic xstr2_req,
	output logic help_shown,
	output logic [1:0] help_screen,
	output logic [MAIN_W-1:0] main_count,
	output logic [TOTAL_W-1:0] total_count
);
	// start bus and digit register are sized for exactly six tests
	if (post_pkg::TEST_COUNT != 6) begin : g_bad_count
		$error("post_supervisor: test count unsupported");
	end

	post_pkg::post_state_t state_q, state_d;
	logic [2:0] test_q, test_d;
	logic [2:0] fail_q, fail_d;
	logic [1:0] nv_q, nv_d;
	logic reply_q;
	logic [7:0] rep1_q;
	logic help_on_q;
	logic [1:0] screen_q;
	logic up_rise, dn_rise;
	logic rk_rise, hk_rise, dk_rise;

	// all checks below live on sys_clk and rest during reset
	default clocking cb_sys @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	// count inputs are closures to common, so the edge of interest is fall
	input_sync u_up (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(~up_input_n),
		.level(),
		.rise(up_rise)
	);
	input_sync u_dn (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(~down_input_n),
		.level(),
		.rise(dn_rise)
	);
	input_sync u_rk (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(reset_key),
		.level(),
		.rise(rk_rise)
	);
	input_sync u_hk (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(help_key),
		.level(),
		.rise(hk_rise)
	);
	input_sync u_dk (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(down_key),
		.level(),
		.rise(dk_rise)
	);

	wire is_run = (state_q == post_pkg::ST_RUN);
	wire is_err = (state_q == post_pkg::ST_ERROR);
	wire recover_ok = is_err & rk_rise &
		((fail_q == post_pkg::TEST_RUN_DATA) |
		(fail_q == post_pkg::TEST_USER_OPT));

	function automatic logic [5:0] onehot_test(input logic [2:0] n);
		onehot_test = 6'h01 << n;
	endfunction

	always_comb begin
		state_d = state_q;
		test_d = test_q;
		fail_d = fail_q;
		nv_d = 2'b00;
		case (state_q)
			post_pkg::ST_IDLE: begin
				test_d = post_pkg::TEST_PROG_MEM;
				state_d = post_pkg::ST_START;
			end
			post_pkg::ST_START: state_d = post_pkg::ST_WAIT;
			post_pkg::ST_WAIT: begin
				if (test_done && !test_pass) begin
					fail_d = test_q;
					state_d = post_pkg::ST_ERROR;
				end else if (test_done && test_q == post_pkg::TEST_LAST) begin
					state_d = post_pkg::ST_RUN;
				end else if (test_done) begin
					test_d = test_q + 3'h1;
					state_d = post_pkg::ST_START;
				end
			end
			post_pkg::ST_RUN: state_d = post_pkg::ST_RUN;
			post_pkg::ST_ERROR: begin
				if (recover_ok) begin
					nv_d = (fail_q == post_pkg::TEST_RUN_DATA) ? 2'b01 : 2'b10;
					state_d = post_pkg::ST_RECOVER;
				end
			end
			post_pkg::ST_RECOVER: state_d = post_pkg::ST_IDLE;
			default: state_d = post_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= post_pkg::ST_IDLE;
			test_q <= 3'h0;
			fail_q <= 3'h0;
			nv_q <= 2'b00;
		end else begin
			state_q <= state_d;
			test_q <= test_d;
			fail_q <= fail_d;
			nv_q <= nv_d;
		end
	end

	// one start pulse per test; the test bank is numbered 0..5
	assign test_start = (state_q == post_pkg::ST_START) ?
		onehot_test(test_q) : 6'h00;

	// bit 0 clears run data, bit 1 loads factory options, one cycle
	assign nv_action = nv_q;

	count_core #(
		.MAIN_W(MAIN_W),
		.TOTAL_W(TOTAL_W)
	) u_count (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.enable(is_run),
		.up_pulse(up_rise),
		.down_pulse(dn_rise),
		.clear_run(nv_q[0]),
		.main_count(main_count),
		.total_count(total_count)
	);

	// serial reply: in error always N plus the digit
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reply_q <= 1'b0;
			rep1_q <= 8'h00;
		end else begin
			reply_q <= cmd_valid & is_err;
			rep1_q <= post_pkg::CHAR_ZERO + {5'h00, fail_q};
		end
	end
	assign reply_valid = reply_q;
	assign reply_char0 = post_pkg::CHAR_N;
	assign reply_char1 = rep1_q;

	// help screens only in run mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			help_on_q <= 1'b0;
			screen_q <= 2'h0;
		end else if (!is_run) begin
			help_on_q <= 1'b0;
			screen_q <= 2'h0;
		end else if (hk_rise) begin
			help_on_q <= 1'b1;
			screen_q <= 2'h1;
		end else if (dk_rise && help_on_q) begin
			screen_q <= 2'h2;
		end
	end
	assign help_shown = help_on_q;
	assign help_screen = screen_q;

	assign running = is_run;
	assign error_shown = is_err;
	assign error_digit = fail_q;
	// outputs only follow requests in run mode
	assign relay_out = is_run & relay_req;
	assign xstr1_out = is_run & xstr1_req;
	assign xstr2_out = is_run & xstr2_req;

	AST_ERR_OUTPUTS_OFF: assert property (
		error_shown |-> !relay_out && !xstr1_out && !xstr2_out)
		else $error("output active in error state");

	// outputs stay dropped out while the series is still running too
	AST_OUTPUTS_IDLE: assert property (
		!running |-> !relay_out && !xstr1_out && !xstr2_out)
		else $error("output active outside run mode");

	AST_ERR_REPLY: assert property (
		cmd_valid && is_err |=> reply_valid
		&& reply_char0 == post_pkg::CHAR_N
		&& reply_char1 == post_pkg::CHAR_ZERO + {5'h00, $past(fail_q)})
		else $error("error reply wrong");

	AST_NO_REPLY_RUN: assert property (
		!(cmd_valid && is_err) |=> !reply_valid)
		else $error("reply outside error state");

	AST_FAIL_HOLDS: assert property (
		is_err && !rk_rise |=> is_err && $stable(fail_q))
		else $error("error state left without recovery");

	AST_NO_COUNT_ERR: assert property (
		is_err && !nv_q[0] |=> $stable(main_count) && $stable(total_count))
		else $error("counting while in error");

	// recovery walk: action pulse, counts cleared, then test 0 again
	sequence s_clear_req;
		is_err && rk_rise && fail_q == post_pkg::TEST_RUN_DATA;
	endsequence
	sequence s_clear_walk;
		nv_action == 2'b01 ##2 main_count == '0 && total_count == '0
		&& state_q == post_pkg::ST_START;
	endsequence
	AST_CLEAR_RUN: assert property (
		s_clear_req |=> s_clear_walk)
		else $error("run data recovery wrong");

	sequence s_load_req;
		is_err && rk_rise && fail_q == post_pkg::TEST_USER_OPT;
	endsequence
	AST_LOAD_OPT: assert property (
		s_load_req |=> nv_action == 2'b10 ##1 state_q == post_pkg::ST_IDLE
		##1 test_start == 6'h01)
		else $error("option recovery wrong");

	AST_NO_RECOVER_OTHER: assert property (
		is_err && fail_q != post_pkg::TEST_RUN_DATA
		&& fail_q != post_pkg::TEST_USER_OPT
		|=> is_err && nv_action == 2'b00)
		else $error("recovery from fatal test");

	AST_TEST_ORDER: assert property (
		state_q == post_pkg::ST_WAIT && test_done && test_pass
		&& test_q != post_pkg::TEST_LAST
		|=> test_q == $past(test_q) + 3'h1
		&& test_start == (6'h01 << ($past(test_q) + 3'h1)))
		else $error("test order broken");

	AST_LAST_PASS: assert property (
		state_q == post_pkg::ST_WAIT && test_done && test_pass
		&& test_q == post_pkg::TEST_LAST |=> running && test_start == 6'h00)
		else $error("normal operation not entered after series");

	AST_FIRST_TEST: assert property (
		state_q == post_pkg::ST_IDLE |=> test_start == 6'h01)
		else $error("series does not start at test 0");

	AST_UP_COUNT: assert property (
		is_run && up_rise && !dn_rise
		|=> main_count == $past(main_count) + 1'b1
		&& total_count == $past(total_count) + 1'b1)
		else $error("up count failed");

	AST_DOWN_COUNT: assert property (
		is_run && dn_rise && !up_rise
		|=> main_count == $past(main_count) - 1'b1
		&& total_count == $past(total_count) - 1'b1)
		else $error("down count failed");

	AST_HELP: assert property (
		is_run && hk_rise |=> help_shown && help_screen == 2'h1)
		else $error("help screen 1 not shown");

	AST_HELP_SECOND: assert property (
		is_run && help_shown && dk_rise && !hk_rise |=> help_screen == 2'h2)
		else $error("help screen 2 not shown");

	AST_HELP_OFF: assert property (
		!is_run |=> !help_shown && help_screen == 2'h0)
		else $error("help screen outside run mode");

	AST_ERR_DIGIT: assert property (
		state_q == post_pkg::ST_WAIT && test_done && !test_pass
		|=> error_shown && error_digit == $past(test_q))
		else $error("error digit wrong");
endmodule

// *** hw/post_pkg.sv ***
// shared constants for the power-on self-test supervisor
// Overview of operation
// - run the whole self-test series after every power-up, before normal work
// - on a fault, display ERROR and the single failing test digit
// - suspend all counting and control while an error code shows
// - hold relay and both transistor outputs dropped out in error state
// - answer every serial command in error state with N and test number
// - test 0 program memory, test 1 working memory, test 2 display driver
// - tests 3, 4, 5 check run data, user options, whole nonvolatile store
// - error 3 plus reset key: zero counts and presets, then rerun tests
// - error 4 plus reset key: restore factory options, then rerun tests
// - default settings: up input closure increments counter and totalizer
// - default settings: down input closure decrements counter and totalizer
// - help key shows screen 1, down arrow shows screen 2, 16 chars each
package post_pkg;
	localparam int TEST_COUNT = 6;
	localparam logic [2:0] TEST_PROG_MEM = 3'h0;
	localparam logic [2:0] TEST_WORK_MEM = 3'h1;
	localparam logic [2:0] TEST_DISPLAY = 3'h2;
	localparam logic [2:0] TEST_RUN_DATA = 3'h3;
	localparam logic [2:0] TEST_USER_OPT = 3'h4;
	localparam logic [2:0] TEST_NV_STORE = 3'h5;
	localparam logic [2:0] TEST_LAST = 3'h5;
	localparam logic [7:0] CHAR_N = 8'h4e;
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	localparam int HELP_CHARS = 16;
	localparam int HELP_SCREENS = 2;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_START = 6'b00_0010,
		ST_WAIT = 6'b00_0100,
		ST_RUN = 6'b00_1000,
		ST_ERROR = 6'b01_0000,
		ST_RECOVER = 6'b10_0000
	} post_state_t;
	typedef enum logic [1:0] {
		REC_NONE = 2'b01,
		REC_CLEAR_RUN = 2'b10
	} unused_t;
endpackage

// *** hw/input_sync.sv ***
// two-stage synchroniser plus rising-edge pulse for one front-panel input
`timescale 1ns/1ps
module input_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic async_in,
	output logic level,
	output logic rise
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// meta_q feeds only sync_q
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~last_q;
endmodule

// *** hw/count_core.sv ***
// main counter and totalizer, default add/subtract count mode
`timescale 1ns/1ps
module count_core #(
	parameter int MAIN_W = 20,
	parameter int TOTAL_W = 27
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic up_pulse,
	input wire logic down_pulse,
	input wire logic clear_run,
	output logic [MAIN_W-1:0] main_count,
	output logic [TOTAL_W-1:0] total_count
);
	// totalizer must hold at least as much as the main counter
	if (MAIN_W < 1 || TOTAL_W < MAIN_W) begin : g_bad_width
		$error("count_core: widths unsupported");
	end

	logic [MAIN_W-1:0] main_q;
	logic [TOTAL_W-1:0] total_q;
	wire inc = enable & up_pulse & ~down_pulse;
	wire dec = enable & down_pulse & ~up_pulse;

	// both closures together cancel, so nothing moves
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			main_q <= '0;
			total_q <= '0;
		end else if (clear_run) begin
			main_q <= '0;
			total_q <= '0;
		end else if (inc) begin
			main_q <= main_q + 1'b1;
			total_q <= total_q + 1'b1;
		end else if (dec) begin
			main_q <= main_q - 1'b1;
			total_q <= total_q - 1'b1;
		end
	end

	assign main_count = main_q;
	assign total_count = total_q;
endmodule

// *** verification/test_bank_model.sv ***
// behavioural self-test bank answering the supervisor's start pulses
`timescale 1ns/1ps
module test_bank_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [5:0] test_start,
	input wire logic [2:0] fail_num,
	input wire logic [3:0] delay,
	output logic test_done,
	output logic test_pass
);
	logic busy_q;
	logic noise_q;
	logic [3:0] cnt_q;
	logic [2:0] cur_q;

	function automatic logic [2:0] index_of(input logic [5:0] s);
		index_of = 3'h0;
		for (int i = 0; i < 6; i++) begin
			if (s[i]) begin
				index_of = 3'(i);
			end
		end
	endfunction

	// pass flag toggles outside the done pulse so stale values never match
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
			noise_q <= 1'b0;
			cnt_q <= 4'h0;
			cur_q <= 3'h0;
			test_done <= 1'b0;
			test_pass <= 1'b0;
		end else begin
			noise_q <= ~noise_q;
			test_done <= 1'b0;
			test_pass <= noise_q;
			if (|test_start) begin
				busy_q <= 1'b1;
				cnt_q <= delay;
				cur_q <= index_of(test_start);
			end else if (busy_q && cnt_q == 4'h0) begin
				busy_q <= 1'b0;
				test_done <= 1'b1;
				test_pass <= (cur_q != fail_num);
			end else if (busy_q) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule

// *** verification/power_on_self_test_supervisor_tb.sv ***
// self-checking bench for the power-on self-test supervisor
`timescale 1ns/1ps
module power_on_self_test_supervisor_tb;
	logic sys_clk = 1'b0, reset_n = 1'b0, test_done, test_pass;
	logic up_input_n = 1'b1, down_input_n = 1'b1, reset_key = 1'b0;
	logic help_key = 1'b0, down_key = 1'b0, cmd_valid = 1'b0;
	logic relay_req = 1'b0, xstr1_req = 1'b0, xstr2_req = 1'b0;
	logic reply_valid, running, error_shown, help_shown;
	logic relay_out, xstr1_out, xstr2_out;
	logic [5:0] test_start;
	logic [7:0] reply_char0, reply_char1, rnd;
	logic [1:0] nv_action, help_screen, nv_seen;
	logic [2:0] error_digit, fail_num = 3'h7;
	logic [3:0] delay = 4'h2;
	logic [19:0] main_count;
	logic [26:0] total_count;
	int errors = 0, n_tests = 0, exp_next = 0, n, m;

	always #10 sys_clk = ~sys_clk;

	post_supervisor dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.test_start(test_start), .test_done(test_done),
		.test_pass(test_pass), .up_input_n(up_input_n),
		.down_input_n(down_input_n), .reset_key(reset_key),
		.help_key(help_key), .down_key(down_key), .cmd_valid(cmd_valid),
		.reply_valid(reply_valid), .reply_char0(reply_char0),
		.reply_char1(reply_char1), .nv_action(nv_action),
		.running(running), .error_shown(error_shown),
		.error_digit(error_digit), .relay_out(relay_out),
		.xstr1_out(xstr1_out), .xstr2_out(xstr2_out),
		.relay_req(relay_req), .xstr1_req(xstr1_req),
		.xstr2_req(xstr2_req), .help_shown(help_shown),
		.help_screen(help_screen), .main_count(main_count),
		.total_count(total_count));

	test_bank_model bank (.sys_clk(sys_clk), .reset_n(reset_n),
		.test_start(test_start), .fail_num(fail_num), .delay(delay),
		.test_done(test_done), .test_pass(test_pass));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [1:0] exp_nv(input int k);
		return (k == 3) ? 2'b01 : 2'b10;
	endfunction

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(negedge sys_clk);
	endtask

	task automatic set_in(input int w, input logic v);
		case (w)
			0: up_input_n = ~v;
			1: down_input_n = ~v;
			2: reset_key = v;
			3: help_key = v;
			default: down_key = v;
		endcase
	endtask

	// held long enough for the two-stage sync and edge detect
	task automatic press(input int w);
		set_in(w, 1'b1);
		tick(4);
		set_in(w, 1'b0);
		tick(4);
	endtask

	task automatic boot(input logic [2:0] f);
		fail_num = f;
		delay = rnd[3:0];
		rnd = lfsr(rnd);
		reset_n = 1'b0;
		tick(3);
		reset_n = 1'b1;
	endtask

	task automatic wait_st(input logic err);
		int i;
		for (i = 0; i < 300; i++) begin
			if ((err ? error_shown : running) === 1'b1) begin
				break;
			end
			tick(1);
		end
		if (i == 300) begin
			errors++;
			$display("[ERR] %0t wait ran out", $time);
			print_verdict;
		end
	endtask

	task automatic send_cmd;
		cmd_valid = 1'b1;
		tick(1);
		cmd_valid = 1'b0;
	endtask

	// start order monitor; a start of test 0 begins a new series
	// sampled mid-cycle, where the one-cycle pulses have settled
	always @(negedge sys_clk) begin
		nv_seen = nv_seen | nv_action;
		if (test_start === 6'h01) begin
			exp_next = 1;
		end else if (|test_start) begin
			chk(test_start === (6'h01 << exp_next), "start order");
			exp_next++;
		end
	end

	initial begin
		rnd = 8'h5b;
		nv_seen = 2'b00;
		boot(3'h7);
		wait_st(1'b0);
		chk(exp_next == 6, "not all tests ran");
		n = int'(rnd[1:0]) + 1;
		m = int'(rnd[3:2]) + 2;
		rnd = lfsr(rnd);
		repeat (n) press(0);
		repeat (m) press(1);
		chk(main_count === 20'(n - m), "main count");
		chk(total_count === 27'(n - m), "total count");
		{relay_req, xstr1_req, xstr2_req} = 3'b101;
		tick(1);
		chk({relay_out, xstr1_out, xstr2_out} === 3'b101, "outputs");
		send_cmd();
		chk(reply_valid === 1'b0, "reply outside error");
		press(3);
		chk(help_shown === 1'b1 && help_screen === 2'h1, "help 1");
		press(4);
		chk(help_screen === 2'h2, "help 2");
		for (int k = 0; k < 6; k++) begin
			boot(3'(k));
			wait_st(1'b1);
			chk(error_digit === 3'(k) && exp_next == k + 1, "digit");
			{relay_req, xstr1_req, xstr2_req} = 3'b111;
			press(0);
			chk({relay_out, xstr1_out, xstr2_out} === 3'b000, "out on");
			chk(main_count === 20'h0_0000 && running === 1'b0, "ran");
			send_cmd();
			chk(reply_valid === 1'b1, "no reply");
			chk(reply_char0 === 8'h4e, "reply letter");
			chk(reply_char1 === 8'h30 + 8'(k), "reply digit");
			fail_num = 3'h7;
			nv_seen = 2'b00;
			press(2);
			if (k == 3 || k == 4) begin
				wait_st(1'b0);
				chk(nv_seen === exp_nv(k), "recovery action");
				chk(main_count === 20'h0_0000, "counts kept");
				chk(exp_next == 6, "series not rerun");
				press(0);
				chk(main_count === 20'h0_0001, "no count after recovery");
			end else begin
				chk(error_shown === 1'b1 && nv_seen === 2'b00, "left");
			end
		end
		print_verdict;
	end
endmodule
